//--- wgs_pkg.sv
// constants shared by the waveform generator auto-shutdown block
// assumes a 32-bit apb slave port and a single 125 mhz clock
`default_nettype none

package wgs_pkg;

   // apb register byte offsets
   localparam logic [11:0] OFF_CTRL0 = 12'h000;  // waveform_control_0
   localparam logic [11:0] OFF_SDC0  = 12'h004;  // shutdown_control_0
   localparam logic [11:0] OFF_SDC1  = 12'h008;  // shutdown_control_1
   localparam logic [11:0] OFF_STAT  = 12'h00c;  // status and irq flag

   // waveform_control_0 fields
   localparam int unsigned CTRL_EN_BIT   = 7;
   localparam int unsigned CTRL_LD_BIT   = 6;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned MODE_W        = 3;

   // shutdown_control_0 fields
   localparam int unsigned SDC0_FORCE_BIT = 7;
   localparam int unsigned SDC0_REN_BIT   = 6;
   localparam int unsigned SDC0_LBD_LSB   = 4;
   localparam int unsigned SDC0_LAC_LSB   = 2;
   localparam int unsigned LVL_W          = 2;

   // status register fields
   localparam int unsigned STAT_IRQ_BIT   = 0;
   localparam int unsigned STAT_RUN_BIT   = 1;
   localparam int unsigned STAT_FAULT_LSB = 8;
   localparam int unsigned MAX_FAULTS     = 8;

   // reset values
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] SDC0_RST  = 8'h00;
   localparam logic [7:0] SDC1_RST  = 8'h00;

   // output mode codes
   localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
   localparam logic [2:0] MODE_SYNC_STEER  = 3'h1;
   localparam logic [2:0] MODE_FWD_BRIDGE  = 3'h2;
   localparam logic [2:0] MODE_REV_BRIDGE  = 3'h3;
   localparam logic [2:0] MODE_HALF_BRIDGE = 3'h4;
   localparam logic [2:0] MODE_PUSH_PULL   = 3'h5;

   // override level codes
   localparam logic [1:0] OVR_INACTIVE = 2'h0;
   localparam logic [1:0] OVR_HIZ      = 2'h1;
   localparam logic [1:0] OVR_LOW      = 2'h2;
   localparam logic [1:0] OVR_HIGH     = 2'h3;

   // synchroniser depth for fault inputs
   localparam int unsigned SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_RUN,
      ST_SHUT,
      ST_WAIT_EDGE
   } wgs_state_t;

endpackage : wgs_pkg

`default_nettype wire

//--- wgs_fault_sync.sv
// three-stage synchroniser for active-low fault levels
// assumes fault inputs are asynchronous to i_ref_clk
`default_nettype none

module wgs_fault_sync #(
   parameter int unsigned N = 6
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rstn,
   input  wire logic         i_clk_en,
   input  wire logic [N-1:0] i_async_n,
   output logic      [N-1:0] o_level_n
);

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] stable;
   } wgs_sync_t;

   wgs_sync_t sync_reg;
   wgs_sync_t sync_next;

   // shift chain; level accepted once stages two and three agree
   always_comb begin
      sync_next    = sync_reg;
      sync_next.s1 = i_async_n;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      for (int i = 0; i < int'(N); i++) begin
         if (sync_reg.s2[i] == sync_reg.s3[i]) begin
            sync_next.stable[i] = sync_reg.s3[i];
         end
      end
   end

   // faults idle high, so reset to inactive
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_reg <= '{s1: '1, s2: '1, s3: '1, stable: '1};
      end else if (i_clk_en) begin
         sync_reg <= sync_next;
      end
   end

   assign o_level_n = sync_reg.stable;

endmodule : wgs_fault_sync

`default_nettype wire

//--- wgs_shutdown.sv
// auto-shutdown, restart and control of the complementary waveform generator
// assumes an apb master on i_ref_clk; fault inputs asynchronous, data input
// from logic on the same clock
//
// Notes on behaviour
// - software setting force-shutdown enters shutdown and drives override levels
// - without auto-restart, shutdown persists while force-shutdown stays set
// - with auto-restart, hardware clears force-shutdown, resumes on next rising edge
// - force-shutdown shows shutdown condition; software and hardware set and clear it
// - enabled fault going active switches outputs to override levels at once
// - six active-low fault sources: pin, three timers, two comparators
// - each fault source has its own enable; disabled sources cause nothing
// - faults are level sensitive; shutdown held while enabled fault persists
// - one 2-bit field sets B and D levels, another sets A and C
// - every shutdown event sets the irq flag
// - no restart until every shutdown source has gone or been disabled
// - software clears force-shutdown; resume on first data rising edge
// - auto-restart clears force-shutdown when faults gone, then resumes on rising edge; the code clears it only on that same rising edge
// - software clear of force-shutdown ignored while a condition is present
// - control bit 7 enables the module, resets to zero
// - load bit loads dead-band buffers on rise after first fall, then self-clears
// - load bit only settable when module already enabled
// - 3-bit mode selects steering, bridge, half-bridge or push-pull; 110, 111 reserved
// - control bits 5 to 3 read zero and ignore writes
//
// Implementation choices: the APB register port and the placing of the registers.
`default_nettype none

module wgs_shutdown #(
   parameter int unsigned N_FAULT = 6
) (
   input  wire logic               i_ref_clk,
   input  wire logic               i_rstn,
   input  wire logic               i_clk_en,
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [11:0]        i_paddr,
   input  wire logic [31:0]        i_pwdata,
   input  wire logic [3:0]         i_pstrb,
   output logic      [31:0]        o_prdata,
   output logic                    o_pready,
   output logic                    o_pslverr,
   input  wire logic [N_FAULT-1:0] i_fault_n,
   input  wire logic               i_wave_data,
   output logic                    o_out_a,
   output logic                    o_out_b,
   output logic                    o_out_c,
   output logic                    o_out_d,
   output logic                    o_oe_a,
   output logic                    o_oe_b,
   output logic                    o_oe_c,
   output logic                    o_oe_d,
   output logic                    o_load_deadband,
   output logic                    o_irq_flag,
   output logic                    o_shutdown_active
);

   // elaboration check on the fault count
   if (N_FAULT < 1 || N_FAULT > wgs_pkg::MAX_FAULTS) begin : g_bad_n
      $error("N_FAULT must lie between 1 and 8");
   end

   typedef struct packed {
      logic               en;
      logic               ld;
      logic [2:0]         mode;
      logic               force_sd;
      logic               auto_rst;
      logic [1:0]         lvl_bd;
      logic [1:0]         lvl_ac;
      logic [N_FAULT-1:0] src_en;
      logic               irq;
      logic               ld_fall_seen;
      logic               ld_pulse;
      logic               data_prev;
      logic               pp_phase;
      wgs_pkg::wgs_state_t st;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
      logic [3:0]         out;
      logic [3:0]         oe;
   } wgs_core_t;

   wgs_core_t core_reg;
   wgs_core_t core_next;

   logic [N_FAULT-1:0] fault_sync_n;
   logic               fault_sync;
   logic               fault_raw;
   logic               rise;
   logic               fall;
   logic               access;
   logic               wr_ok;
   logic               wr_ctrl0;
   logic               wr_sdc0;
   logic               wr_sdc1;
   logic               wr_stat;
   logic               set_cause;

   // fault level synchroniser
   wgs_fault_sync #(
      .N (N_FAULT)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_clk_en  (i_clk_en),
      .i_async_n (i_fault_n),
      .o_level_n (fault_sync_n)
   );

   // address decode: true when the offset is one of the four registers
   function automatic logic addr_hit(input logic [11:0] a);
      return (a == wgs_pkg::OFF_CTRL0) || (a == wgs_pkg::OFF_SDC0) ||
             (a == wgs_pkg::OFF_SDC1) || (a == wgs_pkg::OFF_STAT);
   endfunction : addr_hit

   // override code to drive level, bit 1 is the enable
   function automatic logic [1:0] ovr_drive(input logic [1:0] code);
      logic [1:0] r;
      r = 2'h2;
      unique case (code)
         wgs_pkg::OVR_INACTIVE: r = 2'h2;
         wgs_pkg::OVR_HIZ:      r = 2'h0;
         wgs_pkg::OVR_LOW:      r = 2'h2;
         wgs_pkg::OVR_HIGH:     r = 2'h3;
      endcase
      return r;
   endfunction : ovr_drive

   // normal steering of a, b, c, d from data by mode
   function automatic logic [3:0] steer(input logic [2:0] m, input logic d,
                                        input logic ph);
      logic [3:0] r;
      r = 4'h0;
      case (m)
         wgs_pkg::MODE_ASYNC_STEER,
         wgs_pkg::MODE_SYNC_STEER:  r = {d, d, d, d};
         wgs_pkg::MODE_FWD_BRIDGE:  r = {d, 1'b0, 1'b0, 1'b1};
         wgs_pkg::MODE_REV_BRIDGE:  r = {1'b0, 1'b1, d, 1'b0};
         wgs_pkg::MODE_HALF_BRIDGE: r = {~d, d, ~d, d};
         wgs_pkg::MODE_PUSH_PULL:   r = {1'b0, 1'b0, d & ph, d & ~ph};
         default:                   r = 4'h0;  // reserved codes stay low
      endcase
      return r;
   endfunction : steer

   // fault levels: synced for the flag, raw for the output override
   assign fault_sync = |(~fault_sync_n & core_reg.src_en);
   assign fault_raw  = |(~i_fault_n & core_reg.src_en);

   // data edges, same clock domain
   assign rise = i_wave_data & ~core_reg.data_prev;
   assign fall = ~i_wave_data & core_reg.data_prev;

   // apb write strobes, taken on the edge where pready is high
   assign access   = i_psel & i_penable & core_reg.pready;
   assign wr_ok    = access & i_pwrite & i_pstrb[0];
   assign wr_ctrl0 = wr_ok & (i_paddr == wgs_pkg::OFF_CTRL0);
   assign wr_sdc0  = wr_ok & (i_paddr == wgs_pkg::OFF_SDC0);
   assign wr_sdc1  = wr_ok & (i_paddr == wgs_pkg::OFF_SDC1);
   assign wr_stat  = wr_ok & (i_paddr == wgs_pkg::OFF_STAT);
   assign set_cause = fault_sync | (wr_sdc0 & i_pwdata[wgs_pkg::SDC0_FORCE_BIT]);

   // next-state logic for the whole block
   always_comb begin
      logic [1:0] bd;
      logic [1:0] ac;
      logic [3:0] nrm;
      bd  = ovr_drive(core_reg.lvl_bd);
      ac  = ovr_drive(core_reg.lvl_ac);
      nrm = steer(core_reg.mode, i_wave_data, core_reg.pp_phase);
      core_next = core_reg;
      core_next.data_prev = i_wave_data;
      core_next.ld_pulse  = 1'b0;

      // apb handshake: one wait state, data from a flop
      core_next.pready  = i_psel & i_penable & ~core_reg.pready;
      core_next.pslverr = i_psel & i_penable & ~core_reg.pready & ~addr_hit(i_paddr);
      core_next.prdata  = 32'h0;
      if (i_psel && i_penable && !core_reg.pready && !i_pwrite) begin
         unique case (i_paddr)
            wgs_pkg::OFF_CTRL0: begin
               core_next.prdata[wgs_pkg::CTRL_EN_BIT] = core_reg.en;
               core_next.prdata[wgs_pkg::CTRL_LD_BIT] = core_reg.ld;
               core_next.prdata[2:0] = core_reg.mode;
            end
            wgs_pkg::OFF_SDC0: begin
               core_next.prdata[wgs_pkg::SDC0_FORCE_BIT] = core_reg.force_sd;
               core_next.prdata[wgs_pkg::SDC0_REN_BIT]   = core_reg.auto_rst;
               core_next.prdata[5:4] = core_reg.lvl_bd;
               core_next.prdata[3:2] = core_reg.lvl_ac;
            end
            wgs_pkg::OFF_SDC1: begin
               core_next.prdata[N_FAULT-1:0] = core_reg.src_en;
            end
            wgs_pkg::OFF_STAT: begin
               core_next.prdata[wgs_pkg::STAT_IRQ_BIT] = core_reg.irq;
               core_next.prdata[wgs_pkg::STAT_RUN_BIT] = core_reg.st == wgs_pkg::ST_RUN;
               core_next.prdata[wgs_pkg::STAT_FAULT_LSB +: N_FAULT] = ~fault_sync_n;
            end
            default: core_next.prdata = 32'h0;
         endcase
      end

      // register writes; bits 5:3 of control have no storage
      if (wr_ctrl0) begin
         core_next.en   = i_pwdata[wgs_pkg::CTRL_EN_BIT];
         core_next.mode = i_pwdata[2:0];
      end
      if (wr_sdc0) begin
         core_next.auto_rst = i_pwdata[wgs_pkg::SDC0_REN_BIT];
         core_next.lvl_bd   = i_pwdata[5:4];
         core_next.lvl_ac   = i_pwdata[3:2];
      end
      if (wr_sdc1) begin
         core_next.src_en = i_pwdata[N_FAULT-1:0];
      end

      // dead-band load request: wait for a fall, load on the next rise
      if (core_reg.ld && core_reg.ld_fall_seen && rise) begin
         core_next.ld       = 1'b0;
         core_next.ld_pulse = 1'b1;
      end else if (core_reg.ld && fall) begin
         core_next.ld_fall_seen = 1'b1;
      end
      if (wr_ctrl0 && i_pwdata[wgs_pkg::CTRL_LD_BIT] && core_reg.en) begin
         core_next.ld           = 1'b1;
         core_next.ld_fall_seen = 1'b0;
      end
      if (!core_next.en) begin
         core_next.ld           = 1'b0;
         core_next.ld_fall_seen = 1'b0;
      end

      // force-shutdown: auto clear, software write, then hardware set wins
      if (core_reg.auto_rst && !fault_sync && rise) begin
         core_next.force_sd = 1'b0;
      end
      if (wr_sdc0) begin
         if (i_pwdata[wgs_pkg::SDC0_FORCE_BIT]) begin
            core_next.force_sd = 1'b1;
         end else if (!fault_sync) begin
            core_next.force_sd = 1'b0;
         end
      end
      if (fault_sync) begin
         core_next.force_sd = 1'b1;
      end

      // irq flag: set on each new shutdown, write one clears, set wins
      if (wr_stat && i_pwdata[wgs_pkg::STAT_IRQ_BIT]) begin
         core_next.irq = 1'b0;
      end
      if (core_next.force_sd && !core_reg.force_sd) begin
         core_next.irq = 1'b1;
      end

      // run state machine
      if (!core_reg.en) begin
         core_next.st = core_next.force_sd ? wgs_pkg::ST_SHUT : wgs_pkg::ST_OFF;
      end else begin
         unique case (core_reg.st)
            wgs_pkg::ST_OFF: begin
               core_next.st = core_next.force_sd ? wgs_pkg::ST_SHUT : wgs_pkg::ST_WAIT_EDGE;
            end
            wgs_pkg::ST_RUN: begin
               if (core_next.force_sd) begin
                  core_next.st = wgs_pkg::ST_SHUT;
               end
            end
            wgs_pkg::ST_SHUT: begin
               if (!core_next.force_sd) begin
                  core_next.st = rise ? wgs_pkg::ST_RUN : wgs_pkg::ST_WAIT_EDGE;
               end
            end
            wgs_pkg::ST_WAIT_EDGE: begin
               if (core_next.force_sd) begin
                  core_next.st = wgs_pkg::ST_SHUT;
               end else if (rise) begin
                  core_next.st = wgs_pkg::ST_RUN;
               end
            end
         endcase
      end

      // push-pull alternates on each data rise in the run state
      if (core_reg.st == wgs_pkg::ST_RUN && rise) begin
         core_next.pp_phase = ~core_reg.pp_phase;
      end

      // output drive: off, override, or normal steering
      if (!core_reg.en) begin
         core_next.out = 4'h0;
         core_next.oe  = 4'hf;
      end else if (fault_raw || core_next.st != wgs_pkg::ST_RUN) begin
         core_next.out = {ac[0], bd[0], ac[0], bd[0]};
         core_next.oe  = {ac[1], bd[1], ac[1], bd[1]};
      end else begin
         core_next.out = nrm;
         core_next.oe  = 4'hf;
      end
   end

   // single state register, frozen while clock enable is low
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         core_reg <= '{en: wgs_pkg::CTRL0_RST[wgs_pkg::CTRL_EN_BIT],
                       ld: wgs_pkg::CTRL0_RST[wgs_pkg::CTRL_LD_BIT],
                       mode: wgs_pkg::CTRL0_RST[2:0],
                       force_sd: wgs_pkg::SDC0_RST[wgs_pkg::SDC0_FORCE_BIT],
                       auto_rst: wgs_pkg::SDC0_RST[wgs_pkg::SDC0_REN_BIT],
                       lvl_bd: wgs_pkg::SDC0_RST[5:4],
                       lvl_ac: wgs_pkg::SDC0_RST[3:2],
                       src_en: wgs_pkg::SDC1_RST[N_FAULT-1:0],
                       st: wgs_pkg::ST_OFF,
                       oe: 4'hf,
                       default: '0};
      end else if (i_clk_en) begin
         core_reg <= core_next;
      end
   end

   // outputs straight from the state register
   assign o_prdata          = core_reg.prdata;
   assign o_pready          = core_reg.pready;
   assign o_pslverr         = core_reg.pslverr;
   assign o_out_a           = core_reg.out[3];
   assign o_out_b           = core_reg.out[2];
   assign o_out_c           = core_reg.out[1];
   assign o_out_d           = core_reg.out[0];
   assign o_oe_a            = core_reg.oe[3];
   assign o_oe_b            = core_reg.oe[2];
   assign o_oe_c            = core_reg.oe[1];
   assign o_oe_d            = core_reg.oe[0];
   assign o_load_deadband   = core_reg.ld_pulse;
   assign o_irq_flag        = core_reg.irq;
   assign o_shutdown_active = core_reg.force_sd;

   // checks on the shutdown and control behaviour
   AST_SW_FORCE_SHUT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && wr_sdc0 && i_pwdata[wgs_pkg::SDC0_FORCE_BIT] && core_reg.en
      |=> core_reg.force_sd && core_reg.st == wgs_pkg::ST_SHUT)
      else $error("software force did not enter shutdown");

   AST_HOLD_NO_RESTART: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      core_reg.force_sd && !core_reg.auto_rst && !wr_sdc0 |=> core_reg.force_sd)
      else $error("shutdown left without software clear");

   AST_AUTO_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && core_reg.force_sd && core_reg.auto_rst && !fault_sync && rise
      && !wr_sdc0 |=> !core_reg.force_sd)
      else $error("auto restart did not clear force-shutdown");

   AST_FAULT_OVERRIDE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && core_reg.en && fault_raw |=>
      core_reg.out[3] == ($past(core_reg.lvl_ac) == wgs_pkg::OVR_HIGH) &&
      core_reg.out[2] == ($past(core_reg.lvl_bd) == wgs_pkg::OVR_HIGH) &&
      core_reg.oe[3] == ($past(core_reg.lvl_ac) != wgs_pkg::OVR_HIZ))
      else $error("fault did not force override levels");

   AST_SET_HAS_CAUSE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(core_reg.force_sd) |-> $past(set_cause))
      else $error("shutdown set with no enabled source");

   AST_FAULT_HOLDS: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && fault_sync |=> core_reg.force_sd)
      else $error("shutdown released while fault persists");

   AST_IRQ_ON_EVENT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(core_reg.force_sd) |-> core_reg.irq)
      else $error("shutdown event did not set irq flag");

   AST_CLEAR_NEEDS_QUIET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(core_reg.force_sd) |-> !$past(fault_sync))
      else $error("force-shutdown cleared with source present");

   AST_WAIT_FOR_RISE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && core_reg.en && core_reg.st == wgs_pkg::ST_WAIT_EDGE && !rise
      |=> core_reg.st != wgs_pkg::ST_RUN)
      else $error("resumed without a data rising edge");

   AST_SW_CLEAR_BLOCKED: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && wr_sdc0 && !i_pwdata[wgs_pkg::SDC0_FORCE_BIT] && fault_sync
      |=> core_reg.force_sd)
      else $error("software clear took effect during fault");

   AST_LD_PULSE_CAUSE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      core_reg.ld_pulse |-> $past(core_reg.ld) && $past(core_reg.ld_fall_seen)
      && !core_reg.ld)
      else $error("dead-band load without armed request");

   AST_LD_NEEDS_EN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_clk_en && !core_reg.en && !core_reg.ld && wr_ctrl0 |=> !core_reg.ld)
      else $error("load bit set while module was disabled");

   AST_CTRL_GAP_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      core_reg.pready |-> core_reg.prdata[5:3] == 3'h0 || $past(i_paddr) != wgs_pkg::OFF_CTRL0)
      else $error("control bits 5 to 3 read non-zero");

endmodule : wgs_shutdown

`default_nettype wire

//--- wgs_far_side.sv
// far-side model: six active-low fault sources and the generator data input
// assumes it shares i_ref_clk with the block under test
`default_nettype none

module wgs_far_side (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rstn,
   input  wire logic [5:0] i_fault_req,
   output logic      [5:0] o_fault_n,
   output logic            o_wave_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] div_reg;

   // fault levels: pin, three timers, two comparators; data toggles every 4 cycles
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_fault_n   <= 6'h3f;
         div_reg     <= 2'h0;
         o_wave_data <= 1'b0;
      end else begin
         o_fault_n <= ~i_fault_req;
         div_reg   <= div_reg + 2'h1;
         if (div_reg == 2'h3)
            o_wave_data <= ~o_wave_data;
      end
   end
endmodule : wgs_far_side

`default_nettype wire

//--- wgs_shutdown_tb.sv
// testbench for the auto-shutdown block: apb tasks plus fault and data model
// assumes a 125 mhz clock and the register map of wgs_pkg
`default_nettype none

module wgs_shutdown_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rstn, psel, pen, pwr, pready, pslverr, err, wave, ld, irq, shut;
   logic        oa, ob, oc, od, ea, eb, ec, ed;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  fault_req, fault_n;
   int          error_cnt = 0, samples_checked = 0, ld_cnt = 0, cyc = 0;

   wgs_shutdown u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_fault_n(fault_n),
      .i_wave_data(wave), .o_out_a(oa), .o_out_b(ob), .o_out_c(oc), .o_out_d(od),
      .o_oe_a(ea), .o_oe_b(eb), .o_oe_c(ec), .o_oe_d(ed), .o_load_deadband(ld),
      .o_irq_flag(irq), .o_shutdown_active(shut));
   wgs_far_side u_far (.i_ref_clk(clk), .i_rstn(rstn), .i_fault_req(fault_req),
      .o_fault_n(fault_n), .o_wave_data(wave));

   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // load pulse counter and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ld === 1'b1)
         ld_cnt <= ld_cnt + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         report_and_stop();
      end
   end

   task report_and_stop;
      if (error_cnt == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : chk

   // one apb transfer; result lands in rd and err
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      paddr  <= a;
      pwr    <= w;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd   = prdata;
      err  = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      chk("pready", 1, pready);
   endtask : apb

   task wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk

   // main sequence
   initial begin
      rstn = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; fault_req = 6'h00;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      apb(wgs_pkg::OFF_CTRL0, 1'b0, 32'h0); chk("ctrl0 reset", wgs_pkg::CTRL0_RST, rd);
      apb(wgs_pkg::OFF_SDC0, 1'b0, 32'h0); chk("sdc0 reset", wgs_pkg::SDC0_RST, rd);
      apb(12'h010, 1'b0, 32'h0); chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      for (int m = 0; m < 8; m++) begin
         apb(wgs_pkg::OFF_CTRL0, 1'b1, 32'h80 | m);
         apb(wgs_pkg::OFF_CTRL0, 1'b0, 32'h0); chk("mode", 32'h80 | m, rd);
      end
      apb(wgs_pkg::OFF_CTRL0, 1'b1, 32'h0);
      apb(wgs_pkg::OFF_CTRL0, 1'b1, 32'hff);
      apb(wgs_pkg::OFF_CTRL0, 1'b0, 32'h0); chk("ld with en", 32'h87, rd);
      chk("no early load", 0, ld_cnt);
      apb(wgs_pkg::OFF_CTRL0, 1'b1, 32'hc7); wait_clk(20);
      chk("load pulses", 1, ld_cnt);
      apb(wgs_pkg::OFF_CTRL0, 1'b0, 32'h0); chk("ld cleared", 32'h87, rd);
      // software shutdown: bd driven high, ac driven low
      apb(wgs_pkg::OFF_SDC0, 1'b1, 32'hb8); wait_clk(3);
      chk("force outs", 4'b0101, {oa, ob, oc, od});
      chk("force irq", 1, irq);
      wait_clk(40); chk("force held", 1, shut);
      apb(wgs_pkg::OFF_SDC0, 1'b1, 32'h38); wait_clk(3); chk("sw clear", 0, shut);
      apb(wgs_pkg::OFF_SDC0, 1'b1, 32'h94); wait_clk(3);
      chk("hiz oe", 0, {ea, eb, ec, ed});
      apb(wgs_pkg::OFF_SDC0, 1'b1, 32'h14);
      apb(wgs_pkg::OFF_STAT, 1'b1, 32'h1);
      // disabled sources must not shut down
      apb(wgs_pkg::OFF_SDC1, 1'b1, 32'h1);
      fault_req <= 6'h3e; wait_clk(10); chk("disabled src", 0, shut);
      fault_req <= 6'h00;
      apb(wgs_pkg::OFF_SDC0, 1'b1, 32'h78);
      for (int k = 0; k < 6; k++) begin
         apb(wgs_pkg::OFF_SDC1, 1'b1, 32'h1 << k);
         fault_req <= 6'h01 << k; wait_clk(3);
         chk("fault outs", 4'b0101, {oa, ob, oc, od});
         wait_clk(6); chk("fault flag", 1, shut);
         apb(wgs_pkg::OFF_SDC0, 1'b1, 32'h78);
         apb(wgs_pkg::OFF_SDC0, 1'b0, 32'h0); chk("clear refused", 32'hf8, rd);
         fault_req <= 6'h00; wait_clk(30); chk("auto restart", 0, shut);
         chk("resume outs", 32'h0f, {oa, ob, oc, od, ea, eb, ec, ed});
      end
      apb(wgs_pkg::OFF_CTRL0, 1'b1, 32'h84); wait_clk(3);
      chk("half bridge", 2'b11, {oa ^ ob, oc ^ od});
      apb(wgs_pkg::OFF_CTRL0, 1'b1, 32'h82); wait_clk(3);
      chk("fwd bridge", 3'b001, {ob, oc, od});
      chk("fault irq", 1, irq);
      apb(wgs_pkg::OFF_STAT, 1'b0, 32'h0); chk("stat irq", 1, rd[0]);
      report_and_stop();
   end
endmodule : wgs_shutdown_tb

`default_nettype wire
